// *** mode_select_pkg.sv ***
// Package: constants and types for startup operation mode selection
package mode_select_pkg;

  localparam int unsigned SEL_W = 4;

  // Link startup selection values
  localparam logic [1:0] LINK_OFF     = 2'h0;
  localparam logic [1:0] LINK_ON      = 2'h1;
  localparam logic [1:0] LINK_RESUME  = 2'h2;

  // Operation mode selection values
  localparam logic [3:0] OPS_PNL_OR_EXT  = 4'h0;
  localparam logic [3:0] OPS_PANEL       = 4'h1;
  localparam logic [3:0] OPS_EXTERNAL    = 4'h2;
  localparam logic [3:0] OPS_COMB_PANEL  = 4'h3;
  localparam logic [3:0] OPS_COMB_EXT    = 4'h4;
  localparam logic [3:0] OPS_PROGRAM     = 4'h5;
  localparam logic [3:0] OPS_SWITCHOVER  = 4'h6;
  localparam logic [3:0] OPS_INTERLOCK   = 4'h7;
  localparam logic [3:0] OPS_SIGNAL_SW   = 4'h8;

  // Restart coast time value meaning restart disabled
  localparam logic [15:0] COAST_NO_RESTART = 16'h270F;

  // Operating mode, one-hot
  typedef enum logic [4:0] {
    MODE_EXTERNAL = 5'h01,
    MODE_PANEL    = 5'h02,
    MODE_LINK     = 5'h04,
    MODE_COMBINED = 5'h08,
    MODE_PROGRAM  = 5'h10
  } op_mode_e;

  // Command source split
  typedef struct packed {
    logic cmd_from_panel;
    logic cmd_from_ext;
    logic start_from_panel;
    logic start_from_ext;
  } cmd_src_s;

  // Mode switch requests
  typedef struct packed {
    logic to_external;
    logic to_panel;
    logic to_link;
  } switch_req_s;

  localparam op_mode_e MODE_RESET = MODE_EXTERNAL;

endpackage

// *** startup_operation_mode_select.sv ***
// Module: power-on / restoration operating mode selection
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
module startup_operation_mode_select (
  input  wire logic                          clk_i,
  input  wire logic                          resetn_i,
  input  wire logic                          restore_i,
  input  wire logic                          link_startup_wr_i,
  input  wire logic [1:0]                    link_startup_data_i,
  input  wire logic [3:0]                    operation_mode_select_i,
  input  wire logic [15:0]                   restart_coast_time_i,
  input  wire logic                          panel_interlock_input_i,
  input  wire logic                          mode_switchover_input_i,
  input  wire logic                          running_i,
  input  wire logic                          fwd_cmd_i,
  input  wire logic                          rev_cmd_i,
  input  wire mode_select_pkg::switch_req_s  switch_req_i,
  output logic [4:0]                         op_mode_o,
  output logic [1:0]                         link_startup_select_o,
  output mode_select_pkg::cmd_src_s          cmd_src_o,
  output logic                               switch_while_run_o,
  output logic                               resume_run_o,
  output logic                               switch_refused_o
);

  mode_select_pkg::op_mode_e mode_q;
  mode_select_pkg::op_mode_e start_mode;
  mode_select_pkg::op_mode_e mode_d;
  logic [1:0] link_sel_q;
  logic       eval_pend_q;
  logic       link_req;
  logic       stopped;
  logic       free_switch;
  logic       pre_run_q;
  logic       was_running_q;
  logic       any_req;
  logic       refused_d;

  //////////////////////////////////////////////////////////////////////////////
  // Setting store, no mode gating on purpose
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      link_sel_q <= mode_select_pkg::LINK_OFF;
    end else if (link_startup_wr_i) begin
      link_sel_q <= link_startup_data_i;
    end
  end

  // Setting 3 is undefined and never asks for link startup
  assign link_req = (link_sel_q == mode_select_pkg::LINK_ON) ||
                    (link_sel_q == mode_select_pkg::LINK_RESUME);

  //////////////////////////////////////////////////////////////////////////////
  // Startup decision
  always_comb begin
    start_mode = mode_select_pkg::MODE_EXTERNAL;
    unique case (operation_mode_select_i)
      mode_select_pkg::OPS_PNL_OR_EXT,
      mode_select_pkg::OPS_EXTERNAL: begin
        start_mode = link_req ? mode_select_pkg::MODE_LINK
                              : mode_select_pkg::MODE_EXTERNAL;
      end
      mode_select_pkg::OPS_PANEL: begin
        start_mode = mode_select_pkg::MODE_PANEL;
      end
      mode_select_pkg::OPS_COMB_PANEL,
      mode_select_pkg::OPS_COMB_EXT: begin
        start_mode = mode_select_pkg::MODE_COMBINED;
      end
      mode_select_pkg::OPS_PROGRAM: begin
        start_mode = mode_select_pkg::MODE_PROGRAM;
      end
      mode_select_pkg::OPS_SWITCHOVER: begin
        start_mode = link_req ? mode_select_pkg::MODE_LINK
                              : mode_select_pkg::MODE_EXTERNAL;
      end
      mode_select_pkg::OPS_INTERLOCK: begin
        start_mode = (link_req && panel_interlock_input_i)
                     ? mode_select_pkg::MODE_LINK
                     : mode_select_pkg::MODE_EXTERNAL;
      end
      mode_select_pkg::OPS_SIGNAL_SW: begin
        if (mode_switchover_input_i) begin
          start_mode = link_req ? mode_select_pkg::MODE_LINK
                                : mode_select_pkg::MODE_EXTERNAL;
        end else begin
          start_mode = mode_select_pkg::MODE_PANEL;
        end
      end
      // Undefined selections fall back to the safe external mode
      default: begin
        start_mode = mode_select_pkg::MODE_EXTERNAL;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Switch requests after startup
  assign stopped     = !running_i && !fwd_cmd_i && !rev_cmd_i;
  // Selection 6 lets the mode change while the motor turns
  assign free_switch =
    (operation_mode_select_i == mode_select_pkg::OPS_SWITCHOVER);
  assign any_req = switch_req_i.to_external || switch_req_i.to_panel ||
                   switch_req_i.to_link;

  always_comb begin
    mode_d    = mode_q;
    refused_d = 1'b0;
    if (any_req) begin
      if (!(stopped || free_switch)) begin
        refused_d = 1'b1;
      end else if (switch_req_i.to_external &&
                   (mode_q == mode_select_pkg::MODE_LINK ||
                    mode_q == mode_select_pkg::MODE_PANEL)) begin
        mode_d = mode_select_pkg::MODE_EXTERNAL;
      end else if (switch_req_i.to_panel &&
                   mode_q == mode_select_pkg::MODE_EXTERNAL &&
                   (operation_mode_select_i !=
                      mode_select_pkg::OPS_INTERLOCK ||
                    panel_interlock_input_i)) begin
        mode_d = mode_select_pkg::MODE_PANEL;
      end else if (switch_req_i.to_link &&
                   (mode_q == mode_select_pkg::MODE_EXTERNAL ||
                    (free_switch &&
                     mode_q == mode_select_pkg::MODE_PANEL))) begin
        mode_d = mode_select_pkg::MODE_LINK;
      end else begin
        refused_d = 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Mode register: evaluated once per power-on or restore, then changed only by switch requests
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      eval_pend_q <= 1'b1;
    end else begin
      eval_pend_q <= restore_i;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_q           <= mode_select_pkg::MODE_RESET;
      switch_refused_o <= 1'b0;
    // A request in the evaluation cycle is dropped, so a stale
    // request can never overwrite the fresh startup decision
    end else if (eval_pend_q) begin
      mode_q           <= start_mode;
      switch_refused_o <= 1'b0;
    end else begin
      mode_q           <= mode_d;
      switch_refused_o <= refused_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Run state capture across a power failure
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pre_run_q     <= 1'b0;
      was_running_q <= 1'b0;
      resume_run_o  <= 1'b0;
    end else begin
      was_running_q <= running_i;
      if (restore_i) begin
        pre_run_q <= was_running_q;
      end
      // Only a restore resumes; a full power-on reset never does
      // Coast time 9999 means no restart, so nothing resumes then
      if (eval_pend_q) begin
        resume_run_o <= pre_run_q &&
                        (link_sel_q == mode_select_pkg::LINK_RESUME) &&
                        (restart_coast_time_i !=
                         mode_select_pkg::COAST_NO_RESTART);
      end else if (fwd_cmd_i || rev_cmd_i) begin
        resume_run_o <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Command source split
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cmd_src_o          <= '0;
      switch_while_run_o <= 1'b0;
    end else begin
      switch_while_run_o <= free_switch;
      // Only the combined selections split the two command sources
      cmd_src_o.cmd_from_panel   <=
        (operation_mode_select_i == mode_select_pkg::OPS_COMB_PANEL);
      cmd_src_o.start_from_ext   <=
        (operation_mode_select_i == mode_select_pkg::OPS_COMB_PANEL);
      cmd_src_o.cmd_from_ext     <=
        (operation_mode_select_i == mode_select_pkg::OPS_COMB_EXT);
      cmd_src_o.start_from_panel <=
        (operation_mode_select_i == mode_select_pkg::OPS_COMB_EXT);
    end
  end

  assign op_mode_o             = mode_q;
  assign link_startup_select_o = link_sel_q;

endmodule

// *** mode_select_asserts.sv ***
// Checker: port relations of the startup mode selector
`timescale 1ns/1ps
module mode_select_asserts (
  input wire logic                         clk_i,
  input wire logic                         resetn_i,
  input wire logic                         restore_i,
  input wire logic                         link_startup_wr_i,
  input wire logic [1:0]                   link_startup_data_i,
  input wire logic [3:0]                   operation_mode_select_i,
  input wire logic                         panel_interlock_input_i,
  input wire logic                         mode_switchover_input_i,
  input wire logic                         running_i,
  input wire mode_select_pkg::switch_req_s switch_req_i,
  input wire logic [4:0]                   op_mode_o,
  input wire logic [1:0]                   link_startup_select_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  wire [3:0] s  = operation_mode_select_i;
  wire       r  = restore_i;
  wire       lk = (link_startup_select_o == 2'h1) ||
                  (link_startup_select_o == 2'h2);
  //////////////////////////////////////////////////////////////////////////
  a_setting_write: assert property (link_startup_wr_i |=>
    link_startup_select_o == $past(link_startup_data_i)) else $error("bad set");
  a_link_start: assert property (r && lk && s inside {0,2,6} |->
    ##2 op_mode_o == 5'h04) else $error("no link start");
  a_comb_start: assert property (r && s inside {3, 4} |->
    ##2 op_mode_o == 5'h08) else $error("no combined start");
  a_prog_start: assert property (r && s == 4'h5 |->
    ##2 op_mode_o == 5'h10) else $error("no program start");
  a_panel_start: assert property (r && s == 4'h1 |->
    ##2 op_mode_o == 5'h02) else $error("no panel start");
  a_interlock_off: assert property (r && lk && s == 4'h7 &&
    !panel_interlock_input_i |-> ##2 op_mode_o == 5'h01) else $error("il");
  a_switch_off: assert property (r && s == 4'h8 &&
    !mode_switchover_input_i |-> ##2 op_mode_o == 5'h02) else $error("sw");
  // Restore eval cycles excluded: a request there is dropped, not refused
  a_run_refused: assert property ((|switch_req_i) && running_i &&
    s != 6 && !r && !$past(r) && !$past(r, 2) |=> $stable(op_mode_o))
    else $error("run");
  c_restore_link: cover property (r && lk);
  c_req_run: cover property ((|switch_req_i) && running_i);
  c_interlock: cover property (r && s == 4'h7);
endmodule
bind startup_operation_mode_select mode_select_asserts u_chk (.clk_i,
  .resetn_i, .restore_i, .link_startup_wr_i, .link_startup_data_i,
  .operation_mode_select_i, .panel_interlock_input_i, .running_i,
  .mode_switchover_input_i, .switch_req_i, .op_mode_o, .link_startup_select_o);

// *** host_model.sv ***
// Host computer model: issues mode switch requests over the link
`timescale 1ns/1ps
module host_model (
  input  wire logic                  clk_i,
  output mode_select_pkg::switch_req_s switch_req_o
);
  initial switch_req_o = '0;
  // One request per call; nothing is resent after a power loss
  task automatic request(input mode_select_pkg::switch_req_s kind);
    @(negedge clk_i);
    switch_req_o = kind;
    @(negedge clk_i);
    switch_req_o = '0;
  endtask
endmodule

// *** tb.sv ***
// Testbench: startup table, refused switches, resume and setting writes
`timescale 1ns/1ps
module tb;
  logic clk_i = 0, resetn_i = 0, restore_i = 0, wr = 0, il = 0, sw = 0;
  logic run = 0, fwd = 0, rev = 0, swr, res, rfs;
  logic [1:0] data = 0, lsel;
  logic [3:0] sel = 0;
  logic [15:0] coast = 0;
  logic [4:0] mode;
  mode_select_pkg::switch_req_s req;
  mode_select_pkg::cmd_src_s src;
  int n_errors = 0, checked = 0, cyc = 0;
  always #2 clk_i = ~clk_i;
  startup_operation_mode_select DUT (.clk_i, .resetn_i, .restore_i,
    .link_startup_wr_i(wr), .link_startup_data_i(data),
    .operation_mode_select_i(sel), .restart_coast_time_i(coast),
    .panel_interlock_input_i(il), .mode_switchover_input_i(sw),
    .running_i(run), .fwd_cmd_i(fwd), .rev_cmd_i(rev), .switch_req_i(req),
    .op_mode_o(mode), .link_startup_select_o(lsel), .cmd_src_o(src),
    .switch_while_run_o(swr), .resume_run_o(res), .switch_refused_o(rfs));
  host_model host (.clk_i, .switch_req_o(req));
  //////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (n_errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Table run takes 360 cycles
  always @(posedge clk_i) if (++cyc == 3000) begin
    n_errors++;
    report_and_stop();
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, seen, exp);
    end
  endtask
  function automatic logic [4:0] exp_mode(logic [1:0] l, logic [3:0] s,
                                          logic b);
    if (s inside {4'h3, 4'h4}) return 5'h08;
    if (s == 4'h5) return 5'h10;
    if (s == 4'h1) return 5'h02;
    if (s == 4'h8) return b ? (l != 0 ? 5'h04 : 5'h01) : 5'h02;
    if (l == 2'h0 || s > 4'h8) return 5'h01;
    if (s == 4'h7) return b ? 5'h04 : 5'h01;
    return 5'h04;
  endfunction
  task automatic startup(input logic [1:0] l, input logic [3:0] s, logic b);
    @(negedge clk_i);
    {data, sel, il, sw, wr} = {l, s, b, b, 1'b1};
    @(negedge clk_i);
    {wr, restore_i} = 2'b01;
    @(negedge clk_i);
    restore_i = 0;
    repeat (3) @(negedge clk_i);
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_table();
    for (int l = 0; l < 3; l++)
      for (int s = 0; s < 10; s++)
        for (int b = 0; b < 2; b++) begin
          startup(l[1:0], s[3:0], b[0]);
          chk(mode, exp_mode(l[1:0], s[3:0], b[0]));
          if (s == 3) chk(src, 4'h9);
          if (s == 4) chk(src, 4'h6);
          chk(swr, s == 6);
        end
  endtask
  task automatic t_write();
    startup(2'h1, 4'h2, 1'b0);
    @(negedge clk_i);
    {data, wr} = 3'b101;
    @(negedge clk_i);
    wr = 0;
    @(negedge clk_i);
    chk(lsel, 2'h2);
    chk(mode, 5'h04);
  endtask
  task automatic t_refuse();
    startup(2'h1, 4'h7, 1'b1);
    run = 1;
    host.request(3'h4);
    chk(rfs, 1'b1);
    {run, rev} = 2'b01;
    host.request(3'h4);
    @(negedge clk_i);
    chk(mode, 5'h04);
    rev = 0;
    host.request(3'h4);
    @(negedge clk_i);
    chk(mode, 5'h01);
  endtask
  task automatic t_sel6();
    startup(2'h1, 4'h6, 1'b0);
    run = 1;
    host.request(3'h4);
    @(negedge clk_i);
    chk(mode, 5'h01);
  endtask
  task automatic t_resume();
    startup(2'h2, 4'h2, 1'b0);
    chk(res, 1'b1);
    fwd = 1;
    repeat (2) @(negedge clk_i);
    chk(res, 1'b0);
    {fwd, coast} = {1'b0, mode_select_pkg::COAST_NO_RESTART};
    startup(2'h2, 4'h2, 1'b0);
    chk(res, 1'b0);
    run = 0;
  endtask
  task automatic t_panel();
    startup(2'h0, 4'h7, 1'b0);
    host.request(3'h2);
    chk(rfs, 1'b1);
    chk(mode, 5'h01);
    il = 1;
    host.request(3'h2);
    chk(rfs, 1'b0);
    @(negedge clk_i);
    chk(mode, 5'h02);
  endtask
  task automatic t_power();
    {run, coast} = {1'b1, 16'h0000};
    startup(2'h2, 4'h2, 1'b0);
    chk(res, 1'b1);
    chk(mode, 5'h04);
    resetn_i = 0;
    repeat (2) @(negedge clk_i);
    resetn_i = 1;
    repeat (2) @(negedge clk_i);
    chk(mode, 5'h01);
    chk(res, 1'b0);
    run = 0;
  endtask
  initial begin
    repeat (12) @(negedge clk_i);
    resetn_i = 1;
    repeat (2) @(negedge clk_i);
    chk(mode, 5'h01);
    t_table();
    t_write();
    t_refuse();
    t_sel6();
    t_resume();
    t_panel();
    t_power();
    report_and_stop();
  end
endmodule
